// File: verilog/psra_top.sv
// Power state request arbiter with APB registers
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module psra_top
    import psra_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC,
    parameter int LONG_PRESS_MS = T_LPK_MS,
    parameter bit PD_POL = 1'b1,
    parameter bit RIN_POL = 1'b1,
    parameter int IRQ_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins, asynchronous
    input wire psra_pins_s pins_raw,
    // Internal events, same clock
    input wire logic [IRQ_W-1:0] irq_events,
    input wire logic supply_below_high,
    input wire logic supply_below_low,
    input wire logic die_hot,
    input wire logic thermal_shutdown,
    input wire logic adc_shutdown_event,
    input wire logic sleep_mode,
    input wire logic seq_done,
    // Sequencer requests
    output logic off_to_active_seq,
    output logic active_to_off_seq,
    output logic sleep_to_off_seq,
    output logic wide_reset_level,
    output logic narrow_reset_level,
    output logic [4:0] power_state
);
    localparam int TW = $clog2(TICK_CYC_P);

    function automatic logic [15:0] sat(input logic [15:0] c,
                                        input logic inc);
        sat = (c == 16'hffff) ? c : c + {15'h0000, inc};
    endfunction : sat

    function automatic logic [2:0] first(input logic [7:0] v);
        first = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) first = 3'(i);
        end
    endfunction : first

    ////////////////////////////////////////////////////////////////
    logic [1:0] rs_r;
    logic rst_sync_n;
    psra_pins_s sy1_r, sy2_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_r <= 2'h0;
        end else begin
            rs_r <= {rs_r[0], 1'b1};
        end
    end
    assign rst_sync_n = rs_r[1];

    // Idle button high so no spurious press after reset
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sy1_r <= 4'h8;
            sy2_r <= 4'h8;
        end else begin
            sy1_r <= pins_raw;
            sy2_r <= sy1_r;
        end
    end

    logic btn_low, hold, pd_act, rin_act;
    assign btn_low = !sy2_r.btn_n;
    assign hold = sy2_r.hold;
    assign pd_act = (sy2_r.pd == PD_POL);
    assign rin_act = (sy2_r.rin == RIN_POL);

    ////////////////////////////////////////////////////////////////
    logic device_on_bit_r, device_on_bit_nxt, swrst_r, swrst_nxt;
    psra_cfg_s cfg_r, cfg_nxt;
    logic [7:0] rsel_r, rsel_nxt;
    logic [IRQ_W-1:0] mask_r, mask_nxt;
    logic wd_en_r, wd_en_nxt, wd_lock_r, wd_lock_nxt;
    logic [15:0] wd_per_r, wd_per_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pslverr_r, pslverr_nxt;
    logic wr, wd_kick, dev_off_ev, hit;
    logic [31:0] rd_v;
    psra_state_e st_r, st_nxt;
    logic gate, pend_rst_r, pend_wide_r;

    assign wr = psel && penable && pready_r && pwrite;
    assign wd_kick = wr && (paddr == A_WDOG);
    assign dev_off_ev = wr && (paddr == A_CTRL) && device_on_bit_r
                        && !pwdata[CTRL_DEVICE_ON_BIT];

    always_comb begin
        rd_v = 32'h0;
        hit = 1'b1;
        if (paddr == A_CTRL) begin
            rd_v[CTRL_DEVICE_ON_BIT] = device_on_bit_r;
        end else if (paddr == A_CFG) begin
            rd_v[2:0] = cfg_r;
        end else if (paddr == A_RSEL) begin
            rd_v[7:0] = rsel_r;
        end else if (paddr == A_MASK) begin
            rd_v[IRQ_W-1:0] = mask_r;
        end else if (paddr == A_WDOG) begin
            rd_v[WD_EN] = wd_en_r;
            rd_v[WD_LOCK] = wd_lock_r;
            rd_v[WD_PER_LSB +: 16] = wd_per_r;
        end else if (paddr == A_STAT) begin
            rd_v[11:0] = {sy2_r, gate, pend_rst_r, pend_wide_r,
                          st_r};
        end else begin
            hit = 1'b0;
        end
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        // Answer prepared in setup so access needs no wait
        if (psel && !penable) begin
            prdata_nxt = hit ? rd_v : 32'h0;
            pslverr_nxt = !hit;
        end
        device_on_bit_nxt = device_on_bit_r;
        swrst_nxt = 1'b0;
        cfg_nxt = cfg_r;
        rsel_nxt = rsel_r;
        mask_nxt = mask_r;
        wd_en_nxt = wd_en_r;
        wd_lock_nxt = wd_lock_r;
        wd_per_nxt = wd_per_r;
        if (wr && paddr == A_CTRL) begin
            device_on_bit_nxt = pwdata[CTRL_DEVICE_ON_BIT];
            swrst_nxt = pwdata[CTRL_SOFTWARE_RESET_BIT];
        end
        if (wr && paddr == A_CFG) begin
            cfg_nxt = pwdata[2:0];
        end
        if (wr && paddr == A_RSEL) begin
            rsel_nxt = pwdata[7:0];
        end
        if (wr && paddr == A_MASK) begin
            mask_nxt = pwdata[IRQ_W-1:0];
        end
        if (wd_kick && !wd_lock_r) begin
            wd_en_nxt = pwdata[WD_EN];
            wd_lock_nxt = pwdata[WD_LOCK];
            wd_per_nxt = pwdata[WD_PER_LSB +: 16];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            device_on_bit_r <= 1'b0;
            swrst_r <= 1'b0;
            cfg_r <= CFG_RST;
            rsel_r <= RSEL_RST;
            mask_r <= '1;
            wd_en_r <= 1'b0;
            wd_lock_r <= 1'b0;
            wd_per_r <= WD_PER_RST;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            device_on_bit_r <= device_on_bit_nxt;
            swrst_r <= swrst_nxt;
            cfg_r <= cfg_nxt;
            rsel_r <= rsel_nxt;
            mask_r <= mask_nxt;
            wd_en_r <= wd_en_nxt;
            wd_lock_r <= wd_lock_nxt;
            wd_per_r <= wd_per_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= 1'b1;
            pslverr_r <= pslverr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    logic [TW-1:0] tick_r, tick_nxt;
    logic tick, lpk, rin_deb, wd_to, on_req, narrow_ev, up;
    logic [15:0] press_r, press_nxt, rin_on_r, rin_on_nxt;
    logic [15:0] rin_off_r, rin_off_nxt, wd_cnt_r, wd_cnt_nxt;
    logic [15:0] dly_r, dly_nxt;
    logic arm_r, arm_nxt, hold_d_r;
    logic [IRQ_W-1:0] irq_d_r, irq_edge;
    logic [7:0] offs, imm, dly;
    logic pend_rst_nxt, pend_wide_nxt;
    logic o2a_r, o2a_nxt, a2o_r, a2o_nxt, s2o_r, s2o_nxt;
    logic lw_r, lw_nxt, ln_r, ln_nxt;
    logic dn, dn_wide, dn_rst;

    assign tick = (tick_r == TW'(TICK_CYC_P - 1));
    assign up = (st_r == ST_ACT) || (st_r == ST_DLY);
    // long press once held long enough
    // Free tick: one extra count so a full period has passed
    assign lpk = btn_low && arm_r
                 && (press_r > 16'(LONG_PRESS_MS));
    assign rin_deb = rin_on_r > 16'(T_RIN_OFF_MS);
    assign gate = supply_below_high || die_hot || pd_act || rin_act
                  || (rin_off_r <= 16'(T_RIN_ON_MS));
    assign wd_to = wd_en_r && (wd_cnt_r >= wd_per_r);
    // masked edge events plus button and hold
    assign irq_edge = irq_events & ~irq_d_r & ~mask_r;
    assign on_req = (btn_low && arm_r) || hold || (|irq_edge);
    assign offs = {adc_shutdown_event, supply_below_low, swrst_r,
                   rin_deb, thermal_shutdown, wd_to, pd_act, lpk};
    assign imm = offs & IMM_SET;
    assign dly = offs & ~IMM_SET;
    assign narrow_ev = (dev_off_ev && !hold)
                       || (hold_d_r && !hold && !device_on_bit_r);

    always_comb begin
        tick_nxt = tick ? '0 : tick_r + TW'(1);
        press_nxt = btn_low ? sat(press_r, tick) : 16'h0;
        rin_on_nxt = rin_act ? sat(rin_on_r, tick) : 16'h0;
        rin_off_nxt = rin_act ? 16'h0 : sat(rin_off_r, tick);
        // counts only while enabled and powered
        wd_cnt_nxt = (!wd_en_r || wd_kick || !up) ? 16'h0
                     : sat(wd_cnt_r, tick);
        st_nxt = st_r;
        dly_nxt = dly_r;
        pend_rst_nxt = pend_rst_r;
        pend_wide_nxt = pend_wide_r;
        o2a_nxt = 1'b0;
        a2o_nxt = 1'b0;
        s2o_nxt = 1'b0;
        lw_nxt = 1'b0;
        ln_nxt = 1'b0;
        dn = 1'b0;
        dn_wide = 1'b0;
        dn_rst = 1'b0;
        case (st_r)
            ST_OFF: begin
                // gated restart waits for the gate to lift
                if ((on_req || pend_rst_r) && !gate) begin
                    st_nxt = ST_UP;
                    o2a_nxt = 1'b1;
                    pend_rst_nxt = 1'b0;
                end
            end
            ST_UP: begin
                if (seq_done) st_nxt = ST_ACT;
            end
            ST_ACT, ST_DLY: begin
                if (narrow_ev) begin
                    dn = 1'b1;
                end else if (|imm) begin
                    dn = 1'b1;
                    dn_wide = cfg_r.wide;
                    dn_rst = rsel_r[first(imm)];
                end else if (st_r == ST_ACT && (|dly)) begin
                    st_nxt = ST_DLY;
                    dly_nxt = psra_dly_ms(cfg_r.dly_sel);
                    pend_wide_nxt = cfg_r.wide;
                    pend_rst_nxt = rsel_r[first(dly)];
                end else if (st_r == ST_DLY) begin
                    if (dly_r == 16'h0) begin
                        dn = 1'b1;
                        dn_wide = pend_wide_r;
                        dn_rst = pend_rst_r;
                    end else begin
                        dly_nxt = dly_r - {15'h0000, tick};
                    end
                end
            end
            ST_DOWN: begin
                if (seq_done) begin
                    if (pend_rst_r && !gate) begin
                        st_nxt = ST_UP;
                        o2a_nxt = 1'b1;
                        pend_rst_nxt = 1'b0;
                    end else begin
                        st_nxt = ST_OFF;
                    end
                end
            end
            default: st_nxt = ST_OFF;
        endcase
        if (dn) begin
            st_nxt = ST_DOWN;
            a2o_nxt = !sleep_mode;
            s2o_nxt = sleep_mode;
            lw_nxt = dn_wide;
            ln_nxt = !dn_wide;
            pend_rst_nxt = dn_rst;
            pend_wide_nxt = dn_wide;
        end
        // A held button may not power on again straight away
        arm_nxt = !btn_low || (arm_r && !(dn || st_nxt == ST_DLY));
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tick_r <= '0;
            press_r <= 16'h0;
            rin_on_r <= 16'h0;
            rin_off_r <= 16'h0;
            wd_cnt_r <= 16'h0;
            dly_r <= 16'h0;
            st_r <= ST_OFF;
            pend_rst_r <= 1'b0;
            pend_wide_r <= 1'b0;
            arm_r <= 1'b1;
            hold_d_r <= 1'b0;
            irq_d_r <= '0;
            o2a_r <= 1'b0;
            a2o_r <= 1'b0;
            s2o_r <= 1'b0;
            lw_r <= 1'b0;
            ln_r <= 1'b0;
        end else begin
            tick_r <= tick_nxt;
            press_r <= press_nxt;
            rin_on_r <= rin_on_nxt;
            rin_off_r <= rin_off_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            dly_r <= dly_nxt;
            st_r <= st_nxt;
            pend_rst_r <= pend_rst_nxt;
            pend_wide_r <= pend_wide_nxt;
            arm_r <= arm_nxt;
            hold_d_r <= hold;
            irq_d_r <= irq_events;
            o2a_r <= o2a_nxt;
            a2o_r <= a2o_nxt;
            s2o_r <= s2o_nxt;
            lw_r <= lw_nxt;
            ln_r <= ln_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign off_to_active_seq = o2a_r;
    assign active_to_off_seq = a2o_r;
    assign sleep_to_off_seq = s2o_r;
    assign wide_reset_level = lw_r;
    assign narrow_reset_level = ln_r;
    assign power_state = st_r;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_down_start;
        (a2o_r ^ s2o_r) && (lw_r ^ ln_r) && (st_r == ST_DOWN);
    endsequence

    property p_on_accept;
        st_r == ST_OFF && on_req && !gate |=> o2a_r && st_r == ST_UP;
    endproperty
    a_on_accept: assert property (p_on_accept)
        else $error("on request not accepted");

    property p_gate_block;
        st_r == ST_OFF && gate |=> !o2a_r;
    endproperty
    a_gate_block: assert property (p_gate_block)
        else $error("on request passed a gate");

    property p_mask_rst;
        $rose(rst_sync_n) |-> mask_r == '1 && !wd_en_r;
    endproperty
    a_mask_rst: assert property (p_mask_rst)
        else $error("mask or watchdog wrong after reset");

    property p_imm_off;
        up && (|imm) |=> s_down_start;
    endproperty
    a_imm_off: assert property (p_imm_off)
        else $error("immediate off not taken");

    property p_dly_wait;
        st_r == ST_DLY && dly_r != 16'h0 && !(|imm) && !narrow_ev
            |=> st_r == ST_DLY;
    endproperty
    a_dly_wait: assert property (p_dly_wait)
        else $error("delay cut short");

    property p_narrow;
        up && narrow_ev |=> s_down_start ##0 ln_r && !pend_rst_r;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("forced off not narrow shutdown");

    property p_shutdown;
        st_r == ST_DOWN && seq_done && !pend_rst_r
            |=> st_r == ST_OFF && !o2a_r;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown did not stay off");

    property p_restart;
        st_r == ST_DOWN && seq_done && pend_rst_r && !gate
            |=> o2a_r ##1 st_r == ST_UP;
    endproperty
    a_restart: assert property (p_restart)
        else $error("cold restart missing");

    property p_sleep_seq;
        up && (narrow_ev || (|imm)) && sleep_mode |=> s2o_r && !a2o_r;
    endproperty
    a_sleep_seq: assert property (p_sleep_seq)
        else $error("wrong down sequence from sleep");
endmodule : psra_top

// File: inc/psra_pkg.sv
// Constants and types for the power state request arbiter
//
// Contract
// - Accepted on request runs off-to-active sequence
// - Masked edge events, button, hold request on
// - Gating conditions block every on request
// - On event without gating powers on
// - Accepted off request runs matching down sequence
// - Long button press is a delayed off
// - Common switch-off delay for delayed requests
// - Reset input debounced 1 ms and 26 ms
// - Each delayed or immediate off request applies selected reset level
// - Off request ends in shutdown or restart
// - Shutdown stays off until new on
// - Cold restart returns active once gating lifts
// - Watchdog off at reset, lockable, forces off
// - Clearing device-on bit forces narrow shutdown while hold is low
// - Hold input low forces narrow shutdown while device-on bit is clear; the code acts only on the falling edge of hold
package psra_pkg;
    // Timing
    localparam int CLK_KHZ = 200000;
    localparam int T_TICK_MS = 1;
    localparam int TICK_CYC = CLK_KHZ * T_TICK_MS;
    localparam int T_RIN_OFF_MS = 1;
    localparam int T_RIN_ON_MS = 26;
    localparam int T_LPK_MS = 8000;
    localparam int MS_PER_S = 1000;
    localparam int T_DLY1_S = 1;
    localparam int T_DLY2_S = 2;
    localparam int T_DLY4_S = 4;
    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CFG = 8'h04;
    localparam logic [7:0] A_RSEL = 8'h08;
    localparam logic [7:0] A_MASK = 8'h0c;
    localparam logic [7:0] A_WDOG = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;
    // Field positions
    localparam int CTRL_DEVICE_ON_BIT = 0;
    localparam int CTRL_SOFTWARE_RESET_BIT = 1;
    localparam int CFG_DLY_LSB = 0;
    localparam int CFG_WIDE = 2;
    localparam int WD_EN = 0;
    localparam int WD_LOCK = 1;
    localparam int WD_PER_LSB = 16;
    // Reset values
    localparam logic [7:0] RSEL_RST = 8'h00;
    localparam logic [15:0] WD_PER_RST = 16'h03e8;
    // Off source index: 0 long press, 1 power down, 2 watchdog,
    // 3 thermal, 4 reset input, 5 sw reset, 6 supply low, 7 adc
    localparam int SRC_LPK = 0;
    localparam logic [7:0] IMM_SET = 8'h68;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_UP = 5'h02,
        ST_ACT = 5'h04,
        ST_DLY = 5'h08,
        ST_DOWN = 5'h10
    } psra_state_e;

    typedef struct packed {
        logic btn_n;
        logic hold;
        logic pd;
        logic rin;
    } psra_pins_s;

    typedef struct packed {
        logic wide;
        logic [1:0] dly_sel;
    } psra_cfg_s;

    localparam psra_cfg_s CFG_RST = 3'h4;

    function automatic logic [15:0] psra_dly_ms(input logic [1:0] sel);
        case (sel)
            2'h1: psra_dly_ms = 16'(T_DLY1_S * MS_PER_S);
            2'h2: psra_dly_ms = 16'(T_DLY2_S * MS_PER_S);
            2'h3: psra_dly_ms = 16'(T_DLY4_S * MS_PER_S);
            default: psra_dly_ms = 16'h0000;
        endcase
    endfunction : psra_dly_ms
endpackage : psra_pkg

// File: dv/psra_seq_model.sv
// Sequencer stand-in that answers each power sequence request
`timescale 1ns/1ps
module psra_seq_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Sequence requests
    input wire logic o2a,
    input wire logic a2o,
    input wire logic s2o,
    input wire logic slow,
    // Completion
    output logic seq_done
);
    int cnt;

    ////////////////////////////////////////////////////////////////////////
    // Slow mode stretches a sequence so late sources overlap it
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            seq_done <= 1'b0;
        end else begin
            seq_done <= (cnt == 1);
            if (o2a || a2o || s2o) begin
                cnt <= slow ? 12 : 1;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : psra_seq_model

// File: dv/tb_power_state_request_arbiter.sv
// Self-checking bench for the power state request arbiter
`timescale 1ns/1ps
module tb_power_state_request_arbiter
    import psra_pkg::*;
;
    localparam int TK = 10;
    localparam logic [4:0] EV_UP = 5'h10;
    localparam logic [4:0] EV_DN_W = 5'h0a;
    localparam logic [4:0] EV_DN_N = 5'h09;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    psra_pins_s pins_raw;
    logic [7:0] irq_events;
    logic supply_below_high, supply_below_low, die_hot, thermal_shutdown;
    logic adc_shutdown_event, sleep_mode, seq_done, slow;
    logic o2a, a2o, s2o, wide, narrow;
    logic [4:0] power_state, ev;
    logic [4:0] ev_q[$];
    logic [32:0] rd_q[$];
    int dly[4] = '{0, 1000, 2000, 4000};
    int n_errors = 0;
    int n_tests = 0;
    int n;

    assign ev = {o2a, a2o, s2o, wide, narrow};

    psra_top #(.TICK_CYC_P(TK), .LONG_PRESS_MS(3)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins_raw(pins_raw),
        .irq_events(irq_events), .supply_below_high(supply_below_high),
        .supply_below_low(supply_below_low), .die_hot(die_hot),
        .thermal_shutdown(thermal_shutdown),
        .adc_shutdown_event(adc_shutdown_event), .sleep_mode(sleep_mode),
        .seq_done(seq_done), .off_to_active_seq(o2a),
        .active_to_off_seq(a2o), .sleep_to_off_seq(s2o),
        .wide_reset_level(wide), .narrow_reset_level(narrow),
        .power_state(power_state)
    );
    psra_seq_model seq_u (.ref_clk(ref_clk), .rst_n(rst_n), .o2a(o2a),
        .a2o(a2o), .s2o(s2o), .slow(slow), .seq_done(seq_done));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string nm, input logic [32:0] e,
                       input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic chk_ev(input logic [4:0] e, input logic [4:0] g);
        cmp("sequence request", 33'(e), 33'(g));
    endtask : chk_ev
    task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
        cmp("register read", e, g);
    endtask : chk_rd
    task automatic chk_st(input logic [4:0] e);
        cmp("power state", 33'(e), 33'(power_state));
    endtask : chk_st
    // Phase of the free tick is unknown, so allow one tick early
    task automatic chk_time(input int d, input int g);
        cmp("delay window", 33'h1, 33'(g >= d - TK && g <= d + 3 * TK));
    endtask : chk_time
    // Bounded wait, then the state is compared
    task automatic wait_st(input logic [4:0] e, input int lim, output int c);
        c = 0;
        do begin
            @(negedge ref_clk);
            c++;
        end while (power_state !== e && c < lim);
        chk_st(e);
    endtask : wait_st
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic on_irq();
        int c;
        @(posedge ref_clk);
        irq_events <= 8'h80;
        ev_q.push_back(EV_UP);
        wait_st(ST_ACT, 60, c);
        @(posedge ref_clk);
        irq_events <= 8'h00;
    endtask : on_irq
    task automatic off_ctrl();
        int c;
        wr(A_CTRL, 32'h1);
        ev_q.push_back(EV_DN_N);
        wr(A_CTRL, 32'h0);
        wait_st(ST_OFF, 60, c);
    endtask : off_ctrl
    task automatic complete_run();
        $display("Checks %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    // Results are taken where settled, half a cycle after the edge
    always @(negedge ref_clk) begin
        if (rst_n === 1'b1 && ev !== 5'h00) begin
            chk_ev(ev_q.size() ? ev_q.pop_front() : 5'h00, ev);
        end
    end
    // Read data is taken at the edge that completes the access
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk_rd(rd_q.size() ? rd_q.pop_front() : 33'h0,
                   {pslverr, prdata});
        end
    end

    initial begin
        #500000;
        n_errors++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pins_raw = 4'h8;
        irq_events = 8'h00;
        {supply_below_high, supply_below_low, die_hot} = 3'h0;
        {thermal_shutdown, adc_shutdown_event, sleep_mode, slow} = 4'h0;
        n = $urandom(32'h53875ea6);
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (300) @(posedge ref_clk);
        rd(A_CTRL, 33'h0);
        rd(A_CFG, 33'h4);
        rd(A_RSEL, 33'h0);
        rd(A_MASK, 33'h0ff);
        rd(A_WDOG, 33'h003e80000);
        rd(8'h20, 33'h100000000);
        // gating holds a level request back
        for (int g = 0; g < 2; g++) begin
            @(posedge ref_clk);
            supply_below_high <= (g == 0);
            die_hot <= (g == 1);
            pins_raw.hold <= 1'b1;
            repeat (40) @(negedge ref_clk);
            chk_st(ST_OFF);
            ev_q.push_back(EV_UP);
            @(posedge ref_clk);
            supply_below_high <= 1'b0;
            die_hot <= 1'b0;
            wait_st(ST_ACT, 60, n);
            ev_q.push_back(EV_DN_N);
            @(posedge ref_clk);
            pins_raw.hold <= 1'b0;
            wait_st(ST_OFF, 60, n);
        end
        // device-on bit keeps the device up
        @(posedge ref_clk);
        pins_raw.hold <= 1'b1;
        ev_q.push_back(EV_UP);
        wait_st(ST_ACT, 60, n);
        wr(A_CTRL, 32'h1);
        @(posedge ref_clk);
        pins_raw.hold <= 1'b0;
        repeat (20) @(negedge ref_clk);
        chk_st(ST_ACT);
        off_ctrl();
        // masked edges are lost, unmasked ones switch on
        for (int k = 0; k < 8; k++) begin
            wr(A_MASK, ~(32'h1 << k));
            @(posedge ref_clk);
            irq_events <= 8'($urandom) & ~(8'h1 << k);
            repeat (20) @(negedge ref_clk);
            chk_st(ST_OFF);
            @(posedge ref_clk);
            irq_events <= 8'h1 << k;
            ev_q.push_back(EV_UP);
            wait_st(ST_ACT, 60, n);
            @(posedge ref_clk);
            irq_events <= 8'h00;
            off_ctrl();
        end
        // immediate thermal off, then cold restart
        on_irq();
        wr(A_RSEL, 32'h08);
        ev_q.push_back(EV_DN_W);
        ev_q.push_back(EV_UP);
        @(posedge ref_clk);
        slow <= 1'b1;
        thermal_shutdown <= 1'b1;
        wait_st(ST_DOWN, 10, n);
        @(posedge ref_clk);
        thermal_shutdown <= 1'b0;
        wait_st(ST_ACT, 60, n);
        off_ctrl();
        // every switch-off delay, both reset levels
        wr(A_RSEL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(A_CFG, 32'(i[1:0]) | (i[0] ? 32'h4 : 32'h0));
            on_irq();
            ev_q.push_back({1'b0, i != 2, i == 2, i[0], !i[0]});
            @(posedge ref_clk);
            slow <= 1'b0;
            sleep_mode <= (i == 2);
            pins_raw.pd <= (i < 2);
            adc_shutdown_event <= (i >= 2);
            wait_st(ST_DOWN, 41000, n);
            chk_time(dly[i] * TK, n);
            @(posedge ref_clk);
            pins_raw.pd <= 1'b0;
            adc_shutdown_event <= 1'b0;
            sleep_mode <= 1'b0;
            wait_st(ST_OFF, 60, n);
        end
        // button held past the long-press time
        wr(A_CFG, 32'h4);
        ev_q.push_back(EV_UP);
        ev_q.push_back(EV_DN_W);
        @(posedge ref_clk);
        pins_raw.btn_n <= 1'b0;
        wait_st(ST_ACT, 60, n);
        wait_st(ST_DOWN, 80, n);
        chk_time(3 * TK, n);
        wait_st(ST_OFF, 60, n);
        @(posedge ref_clk);
        pins_raw.btn_n <= 1'b1;
        repeat (40) @(negedge ref_clk);
        chk_st(ST_OFF);
        // short pulse ignored, long one restarts late
        wr(A_RSEL, 32'h10);
        on_irq();
        @(posedge ref_clk);
        pins_raw.rin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        pins_raw.rin <= 1'b0;
        repeat (30) @(negedge ref_clk);
        chk_st(ST_ACT);
        ev_q.push_back(EV_DN_W);
        ev_q.push_back(EV_UP);
        @(posedge ref_clk);
        pins_raw.rin <= 1'b1;
        wait_st(ST_DOWN, 60, n);
        chk_time(TK, n);
        @(posedge ref_clk);
        pins_raw.rin <= 1'b0;
        wait_st(ST_UP, 600, n);
        chk_time(26 * TK, n);
        wait_st(ST_ACT, 60, n);
        // locked watchdog forces the device off
        wr(A_RSEL, 32'h0);
        ev_q.push_back(EV_DN_W);
        wr(A_WDOG, 32'h00050003);
        wr(A_WDOG, 32'h0);
        rd(A_WDOG, 33'h000050003);
        wait_st(ST_OFF, 200, n);
        repeat (20) @(negedge ref_clk);
        chk_ev(5'h00, 5'(ev_q.size()));
        complete_run();
    end
endmodule : tb_power_state_request_arbiter
